// file: rsbw_pkg.sv
// constants and state type for the remote slow buffered write path
// assumes a single system clock; t-states are derived by an enable divider
package rsbw_pkg;
	// system clock period and t-state length, in ns
	localparam int SYS_PERIOD_NS = 10;
	localparam int TSTATE_NS = 20;
	// sys cycles per t-state, and the divider index of the half point
	localparam int TSTATE_CYC = TSTATE_NS / SYS_PERIOD_NS;
	localparam logic [3:0] DIV_LAST = 4'(TSTATE_CYC - 1);
	localparam logic [3:0] DIV_HALF = 4'((TSTATE_CYC / 2) - 1);
	// memory target select codes
	localparam logic [1:0] MS_DATA_MEMORY = 2'h0;
	localparam logic [1:0] MS_INSTRUCTION_MEMORY = 2'h1;
	localparam logic [1:0] MS_PCL = 2'h2;
	localparam logic [1:0] MS_PCH = 2'h3;
	// memory target select field inside the interface config register
	localparam int MS_LSB = 0;
	// reset values
	localparam logic [7:0] RIC_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] INSTR_LOW_HOLDING_LATCH_RESET = 8'h00;
	// remote access machine states
	typedef enum logic [3:0] {
		S_IDLE1, S_IDLE2, S_TAKE, S_SETUP, S_ACC_RIC, S_ACC_PCL,
		S_ACC_PCH, S_ACC_DATA_MEMORY, S_ACC_ILO, S_ACC_IHI, S_TERM, S_REL,
		S_IDLE3
	} rsbw_state_e;
endpackage

// file: rsbw_wait_counter.sv
// programmed wait state down counter for the remote access machine
// assumes load and tick are single-cycle enables on the same clock
`timescale 1ns/1ps
module rsbw_wait_counter (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic tick,
	input wire logic [2:0] load_val,
	output logic done
);
	// remaining wait states
	logic [2:0] cnt_r;

	// load wins over count so a fresh access never inherits old waits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 3'h0;
		end else if (load) begin
			cnt_r <= load_val;
		end else if (tick && cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end

	// all programmed waits inserted
	assign done = (cnt_r == 3'h0);
endmodule // rsbw_wait_counter

// file: rsbw_remote_write.sv
// remote access arbiter, slow buffered write path
// assumes remote pins are synchronous to CLK_SYS and the local timing
// unit joins through the local bus request and grant pair, LOCK_N and LOCAL_REMOTE_WAIT
`timescale 1ns/1ps
module rsbw_remote_write (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic REMOTE_ACCESS_ENABLE,
	input wire logic REMOTE_WRITE_STROBE_N,
	input wire logic CMD_SEL,
	input wire logic WAIT_N,
	input wire logic LOCK_N,
	input wire logic LOCK_OUT_REMOTE_BIT,
	input wire logic LOCAL_BUS_REQUEST,
	input wire logic [1:0] INSTR_WAIT_CFG,
	input wire logic [2:0] DATA_WAIT_CFG,
	input wire logic [7:0] REMOTE_DATA,
	output logic LOCAL_BUS_GRANT,
	output logic LOCAL_REMOTE_WAIT,
	output logic TRANSFER_ACKNOWLEDGE,
	output logic LOCAL_OWNER_N,
	output logic BUS_OE,
	output logic DATA_MEM_WRITE_N,
	output logic INSTR_MEM_WRITE_N,
	output logic [15:0] INSTR_WORD,
	output logic [15:0] PROGRAM_COUNTER,
	output logic [7:0] REMOTE_IFACE_CONFIG,
	output logic HIGH_BYTE_EXPECTED_FLAG
);
	// machine state
	rsbw_pkg::rsbw_state_e state_r;
	// t-state divider
	logic [3:0] div_r;
	// end of a t-state and end of its first half
	logic tick;
	logic half;
	// remote write request
	logic req;
	// decoded state groups
	logic in_idle;
	logic in_access;
	// selected target and wait counter control
	logic [1:0] mem_target_sel;
	logic [2:0] wait_load_val;
	logic wait_done;
	// access bookkeeping
	logic was_instruction_memory_r;
	logic was_hi_r;
	logic was_data_memory_r;
	logic ric_wr_r;
	logic [7:0] ric_pend_r;
	logic [7:0] instr_low_holding_latch_r;
	logic grant_r;

	// true when the config byte points the target at instruction memory
	function automatic logic sel_is_instruction_memory(input logic cmd,
		input logic [1:0] ms);
		sel_is_instruction_memory = !cmd && (ms == rsbw_pkg::MS_INSTRUCTION_MEMORY);
	endfunction

	assign req = REMOTE_ACCESS_ENABLE && !REMOTE_WRITE_STROBE_N;
	assign tick = (div_r == rsbw_pkg::DIV_LAST);
	assign half = (div_r == rsbw_pkg::DIV_HALF);
	assign mem_target_sel = REMOTE_IFACE_CONFIG[rsbw_pkg::MS_LSB +: 2];
	assign in_idle = (state_r == rsbw_pkg::S_IDLE1) ||
		(state_r == rsbw_pkg::S_IDLE2) || (state_r == rsbw_pkg::S_IDLE3);
	assign in_access = (state_r == rsbw_pkg::S_ACC_RIC) ||
		(state_r == rsbw_pkg::S_ACC_PCL) ||
		(state_r == rsbw_pkg::S_ACC_PCH) ||
		(state_r == rsbw_pkg::S_ACC_DATA_MEMORY) ||
		(state_r == rsbw_pkg::S_ACC_ILO) ||
		(state_r == rsbw_pkg::S_ACC_IHI);
	// instruction waits for instruction memory, data waits otherwise
	assign wait_load_val = sel_is_instruction_memory(CMD_SEL, mem_target_sel) ?
		{1'b0, INSTR_WAIT_CFG} : DATA_WAIT_CFG;

	// t-state divider, the only slower rate in the block
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			div_r <= 4'h0;
		end else if (tick) begin
			div_r <= 4'h0;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	rsbw_wait_counter u_wait (
		.clk(CLK_SYS),
		.rst(RST),
		.load(tick && state_r == rsbw_pkg::S_TAKE),
		.tick(tick && in_access),
		.load_val(wait_load_val),
		.done(wait_done)
	);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			state_r <= rsbw_pkg::S_IDLE1;
		end else if (tick) begin
			case (state_r)
				rsbw_pkg::S_IDLE1, rsbw_pkg::S_IDLE3: begin
					if (req && (LOCK_OUT_REMOTE_BIT || grant_r)) begin
						state_r <= rsbw_pkg::S_IDLE2;
					end else if (req && !LOCAL_BUS_REQUEST) begin
						state_r <= rsbw_pkg::S_TAKE;
					end else if (!req) begin
						state_r <= rsbw_pkg::S_IDLE1;
					end
				end
				// held off until lockout, local grant and local request all clear
				rsbw_pkg::S_IDLE2: begin
					if (!req) begin
						state_r <= rsbw_pkg::S_IDLE1;
					end else if (!LOCK_OUT_REMOTE_BIT && !grant_r &&
						!LOCAL_BUS_REQUEST) begin
						state_r <= rsbw_pkg::S_TAKE;
					end
				end
				// one t-state before owner swaps data bus
				rsbw_pkg::S_TAKE: begin
					state_r <= rsbw_pkg::S_SETUP;
				end
				rsbw_pkg::S_SETUP: begin
					if (CMD_SEL) begin
						state_r <= rsbw_pkg::S_ACC_RIC;
					end else if (mem_target_sel == rsbw_pkg::MS_PCL) begin
						state_r <= rsbw_pkg::S_ACC_PCL;
					end else if (mem_target_sel == rsbw_pkg::MS_PCH) begin
						state_r <= rsbw_pkg::S_ACC_PCH;
					end else if (mem_target_sel == rsbw_pkg::MS_DATA_MEMORY) begin
						state_r <= rsbw_pkg::S_ACC_DATA_MEMORY;
					end else if (HIGH_BYTE_EXPECTED_FLAG) begin
						state_r <= rsbw_pkg::S_ACC_IHI;
					end else begin
						state_r <= rsbw_pkg::S_ACC_ILO;
					end
				end
				// remote wait low keeps the access going
				rsbw_pkg::S_ACC_RIC, rsbw_pkg::S_ACC_PCL,
				rsbw_pkg::S_ACC_PCH, rsbw_pkg::S_ACC_DATA_MEMORY,
				rsbw_pkg::S_ACC_ILO, rsbw_pkg::S_ACC_IHI: begin
					if (wait_done && WAIT_N) begin
						state_r <= rsbw_pkg::S_TERM;
					end
				end
				// loop until the remote lets go
				rsbw_pkg::S_TERM: begin
					if (!req) begin
						state_r <= rsbw_pkg::S_REL;
					end
				end
				rsbw_pkg::S_REL: begin
					state_r <= rsbw_pkg::S_IDLE3;
				end
				default: begin
					state_r <= rsbw_pkg::S_IDLE1;
				end
			endcase
		end
	end

	// local grant only while the buses are unused
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			grant_r <= 1'b0;
		end else if (!LOCAL_BUS_REQUEST || !in_idle) begin
			grant_r <= 1'b0;
		end else if (LOCK_N && (state_r != rsbw_pkg::S_IDLE3 ||
			!BUS_OE == 1'b0)) begin
			grant_r <= 1'b1;
		end
	end
	assign LOCAL_BUS_GRANT = grant_r;

	// local access held in remote wait t-states
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			LOCAL_REMOTE_WAIT <= 1'b0;
		end else begin
			LOCAL_REMOTE_WAIT <= LOCAL_BUS_REQUEST && !in_idle;
		end
	end

	// ack low on request, high in termination
	// registered on the fast clock, so it trails the pins by one cycle
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			TRANSFER_ACKNOWLEDGE <= 1'b1;
		end else begin
			TRANSFER_ACKNOWLEDGE <= !(req && state_r != rsbw_pkg::S_TERM);
		end
	end

	// remote owns buses from setup through release
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			LOCAL_OWNER_N <= 1'b0;
		end else begin
			LOCAL_OWNER_N <= !in_idle && state_r != rsbw_pkg::S_TAKE;
		end
	end

	// float at takeover half, drive again at idle half
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			BUS_OE <= 1'b1;
		end else begin
			BUS_OE <= (state_r == rsbw_pkg::S_IDLE1) ||
				(state_r == rsbw_pkg::S_IDLE2) ||
				(state_r == rsbw_pkg::S_TAKE && BUS_OE && !half) ||
				(state_r == rsbw_pkg::S_IDLE3 && (BUS_OE || half));
		end
	end

	// data strobe ends after remote release
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			DATA_MEM_WRITE_N <= 1'b1;
		end else begin
			DATA_MEM_WRITE_N <= !(state_r == rsbw_pkg::S_ACC_DATA_MEMORY ||
				(state_r == rsbw_pkg::S_TERM && was_data_memory_r && req));
		end
	end

	// instruction strobe from setup for the high byte
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			INSTR_MEM_WRITE_N <= 1'b1;
		end else begin
			INSTR_MEM_WRITE_N <= !((state_r == rsbw_pkg::S_SETUP &&
				sel_is_instruction_memory(CMD_SEL, mem_target_sel) &&
				HIGH_BYTE_EXPECTED_FLAG) ||
				state_r == rsbw_pkg::S_ACC_IHI ||
				(state_r == rsbw_pkg::S_TERM && was_hi_r && req));
		end
	end

	// access kind, captured as setup hands over to the access state
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			was_instruction_memory_r <= 1'b0;
			was_hi_r <= 1'b0;
			was_data_memory_r <= 1'b0;
		end else if (tick && state_r == rsbw_pkg::S_SETUP) begin
			was_instruction_memory_r <= sel_is_instruction_memory(CMD_SEL, mem_target_sel);
			was_hi_r <= sel_is_instruction_memory(CMD_SEL, mem_target_sel) &&
				HIGH_BYTE_EXPECTED_FLAG;
			was_data_memory_r <= !CMD_SEL && mem_target_sel == rsbw_pkg::MS_DATA_MEMORY;
		end
	end

	// low byte into holding latch, high byte builds the word
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			instr_low_holding_latch_r <= rsbw_pkg::INSTR_LOW_HOLDING_LATCH_RESET;
			INSTR_WORD <= 16'h0000;
		end else if (tick && state_r == rsbw_pkg::S_SETUP &&
			sel_is_instruction_memory(CMD_SEL, mem_target_sel)) begin
			if (HIGH_BYTE_EXPECTED_FLAG) begin
				INSTR_WORD <= {REMOTE_DATA, instr_low_holding_latch_r};
			end else begin
				instr_low_holding_latch_r <= REMOTE_DATA;
			end
		end
	end

	// config write staged, applied one t-state after completion
	// staging keeps the running access on its old mode
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ric_pend_r <= rsbw_pkg::RIC_RESET;
			ric_wr_r <= 1'b0;
			REMOTE_IFACE_CONFIG <= rsbw_pkg::RIC_RESET;
		end else if (tick && state_r == rsbw_pkg::S_SETUP && CMD_SEL) begin
			ric_pend_r <= REMOTE_DATA;
			ric_wr_r <= 1'b1;
		end else if (tick && state_r == rsbw_pkg::S_REL && ric_wr_r) begin
			REMOTE_IFACE_CONFIG <= ric_pend_r;
			ric_wr_r <= 1'b0;
		end
	end

	// program counter byte writes and word increment
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			PROGRAM_COUNTER <= rsbw_pkg::PC_RESET;
		end else if (tick && state_r == rsbw_pkg::S_SETUP && !CMD_SEL &&
			mem_target_sel == rsbw_pkg::MS_PCL) begin
			PROGRAM_COUNTER[7:0] <= REMOTE_DATA;
		end else if (tick && state_r == rsbw_pkg::S_SETUP && !CMD_SEL &&
			mem_target_sel == rsbw_pkg::MS_PCH) begin
			PROGRAM_COUNTER[15:8] <= REMOTE_DATA;
		end else if (tick && state_r == rsbw_pkg::S_REL && was_hi_r) begin
			PROGRAM_COUNTER <= PROGRAM_COUNTER + 16'h0001;
		end
	end

	// flag cleared by target 01 write, toggled per instruction memory byte
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			HIGH_BYTE_EXPECTED_FLAG <= 1'b0;
		end else if (tick && state_r == rsbw_pkg::S_SETUP && CMD_SEL &&
			REMOTE_DATA[rsbw_pkg::MS_LSB +: 2] == rsbw_pkg::MS_INSTRUCTION_MEMORY) begin
			HIGH_BYTE_EXPECTED_FLAG <= 1'b0;
		end else if (tick && state_r == rsbw_pkg::S_REL && was_instruction_memory_r) begin
			HIGH_BYTE_EXPECTED_FLAG <= !HIGH_BYTE_EXPECTED_FLAG;
		end
	end

	// checks on the machine and its outputs
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence s_rel_tick;
		state_r == rsbw_pkg::S_REL && tick;
	endsequence
	sequence s_enter_setup;
		$rose(state_r == rsbw_pkg::S_SETUP);
	endsequence

	a_idle_hold: assert property (
		(state_r == rsbw_pkg::S_IDLE1 && !req) |=>
		state_r == rsbw_pkg::S_IDLE1)
		else $error("machine left first idle without a request");
	a_lockout_hold: assert property (
		(state_r == rsbw_pkg::S_IDLE2 && req && LOCK_OUT_REMOTE_BIT) |=>
		state_r == rsbw_pkg::S_IDLE2)
		else $error("lockout did not hold the second idle state");
	a_local_grant: assert property (
		(state_r == rsbw_pkg::S_IDLE1 && LOCAL_BUS_REQUEST && LOCK_N &&
		!tick) |=> LOCAL_BUS_GRANT)
		else $error("local request in idle not granted");
	a_ack_low: assert property (
		$rose(req) && state_r != rsbw_pkg::S_TERM |=>
		!TRANSFER_ACKNOWLEDGE)
		else $error("acknowledge did not drop on request");
	a_no_grant_busy: assert property (
		!in_idle |=> !LOCAL_BUS_GRANT)
		else $error("local grant given during remote access");
	a_float_take: assert property (
		(state_r == rsbw_pkg::S_TAKE && half) |=> !BUS_OE [*2])
		else $error("buses not floated in takeover");
	a_setup_owner: assert property (
		s_enter_setup |=> LOCAL_OWNER_N && !TRANSFER_ACKNOWLEDGE)
		else $error("setup did not take ownership");
	a_data_memory_strobe: assert property (
		state_r == rsbw_pkg::S_ACC_DATA_MEMORY |=> !DATA_MEM_WRITE_N)
		else $error("data strobe missing in data access");
	a_term_loop: assert property (
		(state_r == rsbw_pkg::S_TERM && req) |=>
		state_r == rsbw_pkg::S_TERM ##1 TRANSFER_ACKNOWLEDGE)
		else $error("termination left while request held");
	a_release_seq: assert property (
		s_rel_tick |=> state_r == rsbw_pkg::S_IDLE3 ##1 !LOCAL_OWNER_N)
		else $error("release did not reach third idle");
	a_flag_toggle: assert property (
		s_rel_tick ##0 was_instruction_memory_r |=>
		HIGH_BYTE_EXPECTED_FLAG != $past(HIGH_BYTE_EXPECTED_FLAG))
		else $error("high byte flag not toggled");
endmodule // rsbw_remote_write

// file: rsbw_remote_host.sv
// remote host model: one slow buffered write per go pulse
// assumes the device acknowledge is registered on the same clock
`timescale 1ns/1ps
module rsbw_remote_host (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic cmd,
	input wire logic [7:0] data,
	input wire logic [3:0] stall,
	input wire logic ack,
	output logic enable,
	output logic strobe_n,
	output logic cmd_sel,
	output logic [7:0] wdata,
	output logic wait_n,
	output logic done
);
	logic busy_r; // a write cycle is open
	logic seen_r; // acknowledge went low in this cycle
	logic [3:0] cnt_r; // cycles of wait still to hold
	// request, hold, then release once the device lets go
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			seen_r <= 1'b0;
			cnt_r <= 4'h0;
			enable <= 1'b0;
			strobe_n <= 1'b1;
			cmd_sel <= 1'b0;
			wdata <= 8'h00;
			wait_n <= 1'b1;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (go && !busy_r) begin
				busy_r <= 1'b1;
				seen_r <= 1'b0;
				enable <= 1'b1;
				strobe_n <= 1'b0;
				cmd_sel <= cmd;
				wdata <= data;
				cnt_r <= stall;
				wait_n <= (stall == 4'h0);
			end else if (busy_r) begin
				// acknowledge high only counts after it was low
				if (!ack)
					seen_r <= 1'b1;
				if (cnt_r != 4'h0)
					cnt_r <= cnt_r - 4'h1;
				wait_n <= (cnt_r <= 4'h1);
				if (seen_r && ack) begin
					busy_r <= 1'b0;
					enable <= 1'b0;
					strobe_n <= 1'b1;
					cmd_sel <= ~cmd_sel;
					wdata <= ~wdata;
					done <= 1'b1;
				end
			end else begin
				// released bus keeps changing, never a stale value
				wdata <= ~wdata;
			end
		end
	end
endmodule // rsbw_remote_host

// file: rsbw_remote_write_tb.sv
// self-checking bench for the remote slow buffered write path
// assumes the host model answers on the same clock as the device
`timescale 1ns/1ps
module rsbw_remote_write_tb;
	logic clk_sys, rst, lock_n, lock_out_remote_bit, lbr; // clock, reset, arbitration inputs
	logic [1:0] iw; // instruction wait states
	logic [2:0] dw; // data wait states
	logic h_go, h_cmd, h_done; // host control
	logic [7:0] h_data;
	logic [3:0] h_stall;
	logic en, wr_n, cmd_sel, wait_n;
	logic [7:0] rdata;
	logic grant, lrw, ack, own_n, oe, dwr_n, iwr_n, flag;
	logic [15:0] word, pc;
	logic [7:0] cfg;
	int n_errors = 0, n_tests = 0, cyc = 0;
	int t_ack0, t_own, t_wr, t_iwr, t_ack, t_done, t_wrup, t_ownlo;
	int lor_off = -1, lbr_off = -1, lbr_on = -1; // cycle of a mid-run change
	logic bad_oe, bad_gnt, bad_ack, saw_lrw;

	rsbw_remote_write rsbw_remote_write_inst (.CLK_SYS(clk_sys), .RST(rst),
		.REMOTE_ACCESS_ENABLE(en), .REMOTE_WRITE_STROBE_N(wr_n),
		.CMD_SEL(cmd_sel), .WAIT_N(wait_n), .LOCK_N(lock_n),
		.LOCK_OUT_REMOTE_BIT(lock_out_remote_bit), .LOCAL_BUS_REQUEST(lbr),
		.INSTR_WAIT_CFG(iw), .DATA_WAIT_CFG(dw), .REMOTE_DATA(rdata),
		.LOCAL_BUS_GRANT(grant), .LOCAL_REMOTE_WAIT(lrw),
		.TRANSFER_ACKNOWLEDGE(ack), .LOCAL_OWNER_N(own_n), .BUS_OE(oe),
		.DATA_MEM_WRITE_N(dwr_n), .INSTR_MEM_WRITE_N(iwr_n),
		.INSTR_WORD(word), .PROGRAM_COUNTER(pc),
		.REMOTE_IFACE_CONFIG(cfg), .HIGH_BYTE_EXPECTED_FLAG(flag));
	rsbw_remote_host rsbw_remote_host_inst (.clk(clk_sys), .rst(rst),
		.go(h_go), .cmd(h_cmd), .data(h_data), .stall(h_stall), .ack(ack),
		.enable(en), .strobe_n(wr_n), .cmd_sel(cmd_sel), .wdata(rdata),
		.wait_n(wait_n), .done(h_done));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			test_done();
		end
	end

	task automatic test_done();
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_n(input int got, input int lo, input int hi,
		input string what);
		n_tests++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("[ERR] %0t %s count %0d", $time, what, got);
		end
	endtask

	// one remote write; records cycle numbers of each port event
	task automatic run_write(input logic cmd, input logic [7:0] d,
		input logic [3:0] st);
		int c;
		logic fin;
		c = 0;
		fin = 1'b0;
		{t_ack0, t_own, t_wr, t_iwr, t_ack, t_done, t_wrup} = {7{-32'sd1}};
		{bad_oe, bad_gnt, bad_ack, saw_lrw} = 4'h0;
		@(posedge clk_sys);
		h_cmd <= cmd;
		h_data <= d;
		h_stall <= st;
		h_go <= 1'b1;
		@(posedge clk_sys);
		h_go <= 1'b0;
		while (!(fin && own_n === 1'b0) && c < 300) begin
			@(posedge clk_sys);
			if (c == lor_off) lock_out_remote_bit <= 1'b0;
			if (c == lbr_off) lbr <= 1'b0;
			if (c == lbr_on) lbr <= 1'b1;
			#1;
			if (t_ack0 < 0 && ack === 1'b0) t_ack0 = c;
			if (t_own < 0 && own_n === 1'b1) t_own = c;
			if (t_wr < 0 && dwr_n === 1'b0) t_wr = c;
			if (t_iwr < 0 && iwr_n === 1'b0) t_iwr = c;
			if (t_ack < 0 && t_own >= 0 && ack === 1'b1) t_ack = c;
			if (t_ack >= 0 && !fin && ack !== 1'b1) bad_ack = 1'b1;
			if (t_done < 0 && h_done === 1'b1) t_done = c;
			if (t_done >= 0 && t_wrup < 0 && {dwr_n, iwr_n} === 2'h3)
				t_wrup = c;
			if (own_n === 1'b1 && oe !== 1'b0) bad_oe = 1'b1;
			if (own_n === 1'b1 && grant !== 1'b0) bad_gnt = 1'b1;
			if (lrw === 1'b1) saw_lrw = 1'b1;
			if (h_done === 1'b1) fin = 1'b1;
			c++;
		end
		t_ownlo = c - 1;
		// a write that never winds down is a failure, not a silent exit
		chk_n(c, 1, 299, "write limit");
		{lor_off, lbr_off, lbr_on} = {3{-32'sd1}};
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic sc_reset();
		chk_v({8'h00, ack, own_n, oe, dwr_n, iwr_n, grant, lrw, flag},
			16'h00b8, "rst pins");
		chk_v(pc | word | {8'h00, cfg}, 16'h0000, "rst regs");
	endtask
	// data memory write; the longest wait count also meets a local request
	task automatic sc_data_memory(input logic [2:0] w, input logic [3:0] st);
		@(posedge clk_sys);
		dw <= w;
		if (w == 3'h7) lbr_on = 8;
		run_write(1'b0, 8'h5a, st);
		chk_n(t_ack0, 0, 0, "ack low");
		chk_n(t_wr - t_own, 2, 2, "addr settle");
		if (st == 4'h0)
			chk_n(t_ack - t_own, 4 + 2 * int'(w), 4 + 2 * int'(w), "dwait");
		else
			chk_n(t_ack - t_own, 6 + 2 * int'(w), 40, "stretch");
		chk_n(t_wrup - t_done, 1, 1, "strobe end");
		chk_n(t_ownlo - t_done, 4, 5, "release");
		chk_v({13'h0, bad_oe, bad_gnt, bad_ack}, 16'h0000, "hold");
		chk_v(16'(oe), 16'h0001, "bus back");
		if (w == 3'h7) begin
			chk_v(16'(saw_lrw), 16'h0001, "local waited");
			chk_v(16'(grant), 16'h0001, "grant after");
			@(posedge clk_sys);
			lbr <= 1'b0;
		end
	endtask
	// lock holds off the local grant; local grant and lockout each hold off the takeover
	task automatic sc_arb();
		@(posedge clk_sys);
		lock_n <= 1'b0;
		lbr <= 1'b1;
		repeat (4) @(posedge clk_sys);
		lock_n <= 1'b1;
		#1;
		chk_v(16'(grant), 16'h0000, "locked");
		repeat (4) @(posedge clk_sys);
		#1;
		chk_v(16'(grant), 16'h0001, "idle grant");
		lbr_off = 10;
		run_write(1'b0, 8'h3c, 4'h0);
		chk_n(t_ack0, 0, 0, "ack in local");
		chk_n(t_own, 11, 20, "granted wait");
		@(posedge clk_sys);
		lock_out_remote_bit <= 1'b1;
		lor_off = 10;
		run_write(1'b0, 8'hc3, 4'h0);
		chk_n(t_own, 11, 20, "lockout wait");
	endtask
	task automatic sc_pc();
		run_write(1'b1, 8'h02, 4'h0);
		chk_v({8'h00, cfg}, 16'h0002, "config");
		chk_n(t_wr, -1, -1, "no dstrobe");
		run_write(1'b0, 8'h34, 4'h0);
		run_write(1'b1, 8'h03, 4'h0);
		run_write(1'b0, 8'h12, 4'h0);
		chk_v(pc, 16'h1234, "pc bytes");
	endtask
	// a lone low byte, then a word boundary reset and one instruction pair
	task automatic sc_instruction_memory();
		@(posedge clk_sys);
		iw <= 2'h2;
		run_write(1'b1, 8'h01, 4'h0);
		run_write(1'b0, 8'haa, 4'h0);
		chk_v(16'(flag), 16'h0001, "low byte");
		chk_n(t_iwr, -1, -1, "no istrobe");
		chk_v(pc, 16'h1234, "pc kept");
		run_write(1'b1, 8'h01, 4'h0);
		chk_v(16'(flag), 16'h0000, "realign");
		run_write(1'b0, 8'h11, 4'h0);
		run_write(1'b0, 8'h22, 4'h0);
		chk_n(t_iwr - t_own, -1, 0, "early istrobe");
		chk_n(t_ack - t_own, 8, 8, "iwait");
		chk_v(word, 16'h2211, "word");
		chk_v(pc, 16'h1235, "pc step");
		chk_v(16'(flag), 16'h0000, "flag toggle");
	endtask
	// mid-run reset with a low byte pending and every register loaded
	task automatic sc_rst_mid();
		run_write(1'b0, 8'h5a, 4'h0);
		chk_v(16'(flag), 16'h0001, "byte pend");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		sc_reset();
	endtask

	// reset, then the scenarios in an order that leaves each target set
	initial begin
		rst = 1'b1;
		{lock_n, lock_out_remote_bit, lbr, iw, dw} = 8'h80;
		{h_go, h_cmd, h_data, h_stall} = 14'h0000;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		sc_reset();
		sc_data_memory(3'h0, 4'h0);
		sc_data_memory(3'h7, 4'h0);
		sc_data_memory(3'h0, 4'hd);
		sc_arb();
		sc_pc();
		sc_instruction_memory();
		sc_rst_mid();
		test_done();
	end
endmodule // rsbw_remote_write_tb
